/* File: core/qdw_map.svh */
// Constants for the quad converter HS write link and its controller
`ifndef QDW_MAP_SVH
`define QDW_MAP_SVH
// Upper five bits of the HS master code and the full code sent
`define QDW_MCODE_TOP 5'h01
`define QDW_MCODE_BYTE 8'h08
// Upper five bits of the converter's bus address
`define QDW_ADDR_TOP 5'h13
// Control byte fields
`define QDW_CB_PD 0
`define QDW_CB_CH 2:1
`define QDW_CB_HS 3
`define QDW_CB_LOAD 5:4
// Load modes held in the control byte
`define QDW_LOAD_TEMP 2'h0
`define QDW_LOAD_ONE 2'h1
// Channel register reset value
`define QDW_CHAN_RST 14'h0000
// Controller register offsets
`define QDW_REG_CTRL 8'h00
`define QDW_REG_DATA 8'h04
`define QDW_REG_CMD 8'h08
`define QDW_REG_STAT 8'h0C
// Controller register fields
`define QDW_CTRL_CB 7:0
`define QDW_CTRL_SEL 9:8
`define QDW_DATA_SMP 11:0
`define QDW_DATA_PDM 13:12
`define QDW_CMD_GO 0
`define QDW_ST_BUSY 0
`define QDW_ST_ANACK 1
`define QDW_ST_DONE 2
// System clocks per quarter of a bus clock period
`define QDW_SCL_QTR 48
`endif

/* File: core/qdw_pkg.sv */
// Types shared by both ends of the quad converter write link
package qdw_pkg;
  // One channel register: two power bits over twelve data bits
  typedef logic [13:0] qdw_word_t;
  // All four channels
  typedef logic [3:0][13:0] qdw_bank_t;
  // Receiver states
  typedef enum logic [2:0] {
    D_IDLE, D_FIRST, D_CTRL, D_HI, D_LO, D_PDHI, D_PDLO, D_SKIP
  } qdw_dst_t;
  // Controller states
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} qdw_hst_t;
endpackage : qdw_pkg

/* File: core/qdw_if.sv */
// Two-wire bus between the controller and the converter receiver
`timescale 1ns/1ps
`default_nettype none
interface qdw_if;
  // Controller drive of both lines
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  // Receiver drive of the data line
  logic sda_s_o;
  logic sda_s_oe;
  // Resolved open-drain levels, pulled up when nobody drives low
  logic scl;
  logic sda;
  assign scl = (scl_m_oe & ~scl_m_o) ? 1'h0 : 1'h1;
  assign sda = ((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o)) ? 1'h0 : 1'h1;
  modport dev (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport host (
    input scl, input sda,
    output scl_m_o, output scl_m_oe, output sda_m_o, output sda_m_oe
  );
endinterface : qdw_if
`default_nettype wire

/* File: core/qdw_sync.sv */
// Two-flop synchroniser for pin levels, reset to the idle-high level
`timescale 1ns/1ps
`default_nettype none
module qdw_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  // First and second stage
  logic [W-1:0] m_q;
  logic [W-1:0] m_d;
  logic [W-1:0] s_q;
  logic [W-1:0] s_d;
  // Refuse an empty synchroniser
  if (W < 1) begin : g_chk
    $error("qdw_sync width must be at least one");
  end
  // Next stage values, frozen while the enable is low
  always_comb begin
    m_d = ce_i ? d_i : m_q;
    s_d = ce_i ? m_q : s_q;
  end
  // Stage registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      m_q <= '1;
      s_q <= '1;
    end else begin
      m_q <= m_d;
      s_q <= s_d;
    end
  end
  assign q_o = s_q;
endmodule : qdw_sync
`default_nettype wire

/* File: core/qdw_dev.sv */
// Converter end: HS-mode write receiver with four channel registers
// Function
// [RULE1] Master code byte 00001xxx never acknowledged
// [RULE2] Restart, address 10011, selects, write bit, acked
// [RULE3] Control byte: load, HS zero, channel, flag; acked
// [RULE4] High data byte holds sample bits 11..4, acked
// [RULE5] Low byte upper nibble bits 3..0, acked
// [RULE6] Data pairs repeat until stop or restart
// [RULE7] Power-down high byte: mode in bits 7..6, acked
// [RULE8] Power-down low byte acked; only two taken
// [RULE9] Master ends power-down write with stop/restart
// [RULE10] Master should end with restart, stay HS; the controller here ends each write with a stop
// [RULE11] Channel temp/output: two power bits, twelve data
// [RULE12] Control flag picks power-down or sample bytes
`timescale 1ns/1ps
`default_nettype none
`include "qdw_map.svh"
module qdw_dev (
  input wire logic clk_lnk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic addr_select_hi_i,
  input wire logic addr_select_lo_i,
  qdw_if.dev lnk,
  output var qdw_pkg::qdw_bank_t channel_temp_reg_o,
  output var qdw_pkg::qdw_bank_t channel_output_reg_o,
  output logic update_o,
  output logic powerdown_flag_o
);
  import qdw_pkg::*;

  // Synchronised selects and bus lines
  logic [3:0] pin_s;
  logic sel_hi_s;
  logic sel_lo_s;
  logic scl_s;
  logic sda_s;

  // Previous bus levels for edge and condition detection
  logic scl_q;
  logic scl_d;
  logic sda_q;
  logic sda_d;

  // Byte receiver state
  qdw_dst_t st_q;
  qdw_dst_t st_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [7:0] sh_q;
  logic [7:0] sh_d;
  logic ack_q;
  logic ack_d;

  // Held control byte, high data byte and power-down mode
  logic [7:0] ctl_q;
  logic [7:0] ctl_d;
  logic [7:0] hi_q;
  logic [7:0] hi_d;
  logic [1:0] pdm_q;
  logic [1:0] pdm_d;

  // Channel registers and update pulse
  qdw_bank_t temp_q;
  qdw_bank_t temp_d;
  qdw_bank_t out_q;
  qdw_bank_t out_d;
  logic upd_q;
  logic upd_d;
  logic do_upd;

  // Bus events seen on the synchronised lines
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic [1:0] ch;

  // Pins come from the other clock domain: two flops first
  qdw_sync #(.W(4)) u_sync (
    .clk_i(clk_lnk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({addr_select_hi_i, addr_select_lo_i, lnk.scl, lnk.sda}),
    .q_o(pin_s)
  );
  assign sel_hi_s = pin_s[3];
  assign sel_lo_s = pin_s[2];
  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];

  // Clock edges and start or stop while the clock is high
  assign rise = scl_s & ~scl_q;
  assign fall = ~scl_s & scl_q;
  assign start = scl_s & scl_q & sda_q & ~sda_s;
  assign stop = scl_s & scl_q & ~sda_q & sda_s;
  assign ch = ctl_q[`QDW_CB_CH];

  // Next state of the receiver and the channel registers
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    ack_d = ack_q;
    ctl_d = ctl_q;
    hi_d = hi_q;
    pdm_d = pdm_q;
    temp_d = temp_q;
    out_d = out_q;
    upd_d = 1'h0;
    do_upd = 1'h0;
    scl_d = scl_s;
    sda_d = sda_s;
    if (start) begin
      // Start or repeated start: a new first byte follows
      st_d = D_FIRST; // see [RULE2]
      cnt_d = 4'h0;
      ack_d = 1'h0;
    end else if (stop) begin
      // Stop ends any transfer
      st_d = D_IDLE; // see [RULE6]
      ack_d = 1'h0;
    end else if (st_q != D_IDLE) begin
      if (rise && !ack_q && cnt_q != 4'h8) begin
        // Data bit, most significant first
        sh_d = {sh_q[6:0], sda_s};
        cnt_d = 4'(cnt_q + 4'h1);
      end else if (fall && ack_q) begin
        // Acknowledge clock over: let go of the data line
        ack_d = 1'h0;
      end else if (fall && cnt_q == 4'h8) begin
        // Byte complete: decide the answer and act on it
        cnt_d = 4'h0;
        ack_d = 1'h1;
        case (st_q)
          D_FIRST: begin
            if (sh_q[7:3] == `QDW_MCODE_TOP) begin
              // Master code: left unanswered, wait for restart
              ack_d = 1'h0; // see [RULE1]
              st_d = D_IDLE;
            end else if (sh_q[7:1] ==
                {`QDW_ADDR_TOP, sel_hi_s, sel_lo_s} && !sh_q[0]) begin
              // Own address with write direction
              st_d = D_CTRL; // see [RULE2]
            end else begin
              // Another device or a read: stay off the bus
              ack_d = 1'h0;
              st_d = D_IDLE;
            end
          end
          D_CTRL: begin
            // Control byte; the HS bit is not checked
            ctl_d = sh_q; // see [RULE3]
            st_d = sh_q[`QDW_CB_PD] ? D_PDHI : D_HI; // see [RULE12]
          end
          D_HI: begin
            // Sample bits 11..4
            hi_d = sh_q; // see [RULE4]
            st_d = D_LO;
          end
          D_LO: begin
            // Sample bits 3..0; lower nibble dropped, power bits cleared
            temp_d[ch] = {2'h0, hi_q, sh_q[7:4]}; // see [RULE5] [RULE11]
            do_upd = 1'h1;
            st_d = D_HI; // see [RULE6]
          end
          D_PDHI: begin
            // Power-down mode bits
            pdm_d = sh_q[7:6]; // see [RULE7]
            st_d = D_PDLO;
          end
          D_PDLO: begin
            // Second power-down byte: data bits of the channel kept
            temp_d[ch][13:12] = pdm_q; // see [RULE8] [RULE11]
            do_upd = 1'h1;
            st_d = D_SKIP; // see [RULE8]
          end
          default: begin
            // Bytes beyond the power-down pair are refused
            ack_d = 1'h0; // see [RULE9]
            st_d = D_SKIP;
          end
        endcase
      end
    end
    if (do_upd) begin
      // Load mode: temporary only, the chosen channel, or all
      case (ctl_q[`QDW_CB_LOAD])
        `QDW_LOAD_TEMP: upd_d = 1'h0;
        `QDW_LOAD_ONE: begin
          out_d[ch] = temp_d[ch]; // see [RULE11]
          upd_d = 1'h1;
        end
        default: begin
          out_d = temp_d;
          upd_d = 1'h1;
        end
      endcase
    end
  end

  // State registers, frozen while the enable is low
  always_ff @(posedge clk_lnk_i) begin
    if (rst_i) begin
      st_q <= D_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ack_q <= 1'h0;
      ctl_q <= 8'h00;
      hi_q <= 8'h00;
      pdm_q <= 2'h0;
      temp_q <= {4{`QDW_CHAN_RST}};
      out_q <= {4{`QDW_CHAN_RST}};
      upd_q <= 1'h0;
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end else if (ce_i) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      ack_q <= ack_d;
      ctl_q <= ctl_d;
      hi_q <= hi_d;
      pdm_q <= pdm_d;
      temp_q <= temp_d;
      out_q <= out_d;
      upd_q <= upd_d;
      scl_q <= scl_d;
      sda_q <= sda_d;
    end
  end

  // Data line pulled low only while acknowledging
  assign lnk.sda_s_o = 1'h0;
  assign lnk.sda_s_oe = ack_q;
  assign channel_temp_reg_o = temp_q;
  assign channel_output_reg_o = out_q;
  assign update_o = upd_q;
  assign powerdown_flag_o = ctl_q[`QDW_CB_PD];
endmodule : qdw_dev
`default_nettype wire

/* File: core/qdw_host.sv */
// Controller end: APB-programmed HS write master for the converter
`timescale 1ns/1ps
`default_nettype none
`include "qdw_map.svh"
module qdw_host #(
  parameter int QTR = `QDW_SCL_QTR
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  qdw_if.host lnk
);
  import qdw_pkg::*;
  localparam logic [15:0] QTR_M1 = 16'(QTR - 1);
  // Quarter period must allow a setup gap and fit the counter
  if (QTR < 2 || QTR > 65535) begin : g_chk
    $error("qdw_host quarter period out of range");
  end
  // APB slave registers
  logic [31:0] prd_q, prd_d;
  logic rdy_q, rdy_d;
  logic err_q, err_d;
  logic [9:0] ctrl_q, ctrl_d;
  logic [13:0] data_q, data_d;
  logic done_q, done_d;
  logic anack_q, anack_d;
  // Bit sequencer
  qdw_hst_t st_q, st_d;
  logic [1:0] ph_q, ph_d;
  logic [15:0] qc_q, qc_d;
  logic [3:0] bit_q, bit_d;
  logic [2:0] byt_q, byt_d;
  logic scl_q, scl_d;
  logic sda_q, sda_d;
  logic sda_s;
  logic setup, acc, wr, go, mapped, pd;
  logic [7:0] cur;

  // Data line comes from the other domain
  qdw_sync #(.W(1)) u_sync (
    .clk_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(lnk.sda),
    .q_o(sda_s)
  );

  assign setup = psel_i & ~penable_i;
  assign acc = psel_i & penable_i & rdy_q;
  assign wr = acc & pwrite_i & ~err_q;
  assign mapped = paddr_i == `QDW_REG_CTRL || paddr_i == `QDW_REG_DATA ||
    paddr_i == `QDW_REG_CMD || paddr_i == `QDW_REG_STAT;
  assign go = wr && paddr_i == `QDW_REG_CMD && pwdata_i[`QDW_CMD_GO];
  assign pd = ctrl_q[`QDW_CB_PD];

  // Byte on the wire for the current position of the write
  always_comb begin
    case (byt_q)
      3'h0: cur = `QDW_MCODE_BYTE; // see [RULE1]
      3'h1: cur = {`QDW_ADDR_TOP, ctrl_q[`QDW_CTRL_SEL], 1'h0}; // see [RULE2]
      3'h2: cur = ctrl_q[`QDW_CTRL_CB]; // see [RULE3]
      3'h3: cur = pd ? {data_q[`QDW_DATA_PDM], 6'h00}
        : data_q[11:4]; // see [RULE4] [RULE7]
      default: cur = pd ? 8'h00 : {data_q[3:0], 4'h0}; // see [RULE5] [RULE8]
    endcase
  end

  // Register file and sequencer next values
  always_comb begin
    prd_d = prd_q;
    rdy_d = setup;
    err_d = setup & ~mapped;
    ctrl_d = ctrl_q;
    data_d = data_q;
    done_d = done_q;
    anack_d = anack_q;
    st_d = st_q;
    ph_d = ph_q;
    qc_d = qc_q;
    bit_d = bit_q;
    byt_d = byt_q;
    // Read data captured in the setup cycle
    if (setup && !pwrite_i) begin
      case (paddr_i)
        `QDW_REG_CTRL: prd_d = {22'h0, ctrl_q};
        `QDW_REG_DATA: prd_d = {18'h0, data_q};
        `QDW_REG_STAT: prd_d = {29'h0, done_q, anack_q, st_q != H_IDLE};
        default: prd_d = 32'h0;
      endcase
    end
    // Settings are locked while a write runs
    if (wr && st_q == H_IDLE && paddr_i == `QDW_REG_CTRL) begin
      ctrl_d = pwdata_i[9:0];
    end
    if (wr && st_q == H_IDLE && paddr_i == `QDW_REG_DATA) begin
      data_d = pwdata_i[13:0];
    end
    // Write one to clear the sticky flags; a set below wins
    if (wr && paddr_i == `QDW_REG_STAT) begin
      if (pwdata_i[`QDW_ST_DONE]) done_d = 1'h0;
      if (pwdata_i[`QDW_ST_ANACK]) anack_d = 1'h0;
    end
    if (st_q == H_IDLE) begin
      if (go) begin
        st_d = H_START;
        ph_d = 2'h0;
        qc_d = 16'h0;
        byt_d = 3'h0;
      end
    end else if (qc_q != QTR_M1) begin
      qc_d = 16'(qc_q + 16'h1);
    end else begin
      qc_d = 16'h0;
      ph_d = 2'(ph_q + 2'h1);
      if (ph_q == 2'h3) begin
        case (st_q)
          H_START: begin
            st_d = H_BIT;
            bit_d = 4'h0;
          end
          H_BIT: begin
            if (bit_q != 4'h8) begin
              bit_d = 4'(bit_q + 4'h1);
            end else if (byt_q == 3'h0) begin
              // Master code answer ignored; restart into the address
              byt_d = 3'h1;
              st_d = H_START; // see [RULE2] [RULE10]
            end else if (sda_s) begin
              // No answer from the converter: abandon the write
              anack_d = 1'h1;
              st_d = H_STOP;
            end else if (byt_q == 3'h4) begin
              // Pair sent: end the write
              st_d = H_STOP; // see [RULE9]
            end else begin
              byt_d = 3'(byt_q + 3'h1);
              bit_d = 4'h0;
            end
          end
          default: begin
            st_d = H_IDLE;
            done_d = 1'h1;
          end
        endcase
      end
    end
    // Line levels, one meaning released and zero pulled low
    case (st_q)
      H_START: begin
        scl_d = ph_q == 2'h1 || ph_q == 2'h2;
        sda_d = ph_q < 2'h2;
      end
      H_BIT: begin
        scl_d = ph_q[1];
        sda_d = bit_q == 4'h8 ? 1'h1 : cur[3'(4'h7 - bit_q)];
      end
      H_STOP: begin
        scl_d = ph_q != 2'h0;
        sda_d = ph_q[1];
      end
      default: begin
        scl_d = 1'h1;
        sda_d = 1'h1;
      end
    endcase
  end

  // Registers, frozen while the enable is low
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      prd_q <= 32'h0;
      rdy_q <= 1'h0;
      err_q <= 1'h0;
      ctrl_q <= 10'h0;
      data_q <= 14'h0;
      done_q <= 1'h0;
      anack_q <= 1'h0;
      st_q <= H_IDLE;
      ph_q <= 2'h0;
      qc_q <= 16'h0;
      bit_q <= 4'h0;
      byt_q <= 3'h0;
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end else if (ce_i) begin
      prd_q <= prd_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
      ctrl_q <= ctrl_d;
      data_q <= data_d;
      done_q <= done_d;
      anack_q <= anack_d;
      st_q <= st_d;
      ph_q <= ph_d;
      qc_q <= qc_d;
      bit_q <= bit_d;
      byt_q <= byt_d;
      scl_q <= scl_d;
      sda_q <= sda_d;
    end
  end

  assign prdata_o = prd_q;
  assign pready_o = rdy_q;
  assign pslverr_o = err_q;
  // Open drain: drive low only, enable high while pulling low
  assign lnk.scl_m_o = 1'h0;
  assign lnk.scl_m_oe = ~scl_q;
  assign lnk.sda_m_o = 1'h0;
  assign lnk.sda_m_oe = ~sda_q;
endmodule : qdw_host
`default_nettype wire

/* File: bench/qdw_assertions.sv */
// Checker of the two-wire link between controller and receiver
`timescale 1ns/1ps
`default_nettype none
`include "qdw_map.svh"
module qdw_assertions #(
  parameter int QTR = 48
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic addr_select_hi_i,
  input wire logic addr_select_lo_i,
  input wire logic scl_m_o,
  input wire logic scl_m_oe,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  // Longest time the controller may keep the clock line low
  localparam int LOW_MAX = 4 * QTR + 8;
  logic scl_p_q; // Clock line one cycle ago
  logic sda_p_q; // Data line one cycle ago
  logic [3:0] bit_q; // Clock pulses in the current byte slot
  logic [2:0] byte_q; // Byte slots since the last start
  logic [7:0] sh_q; // Bits of the byte in flight
  logic rs_q; // Last start came inside an open frame
  logic frm_q; // A frame is open
  logic aack_q; // Address of this frame was acknowledged
  logic rise;
  logic start_ev;
  logic stop_ev;
  logic ack_slot;
  logic [7:0] addr_exp; // Address the receiver answers to
  assign rise = scl & ~scl_p_q;
  assign start_ev = scl & scl_p_q & sda_p_q & ~sda;
  assign stop_ev = scl & scl_p_q & ~sda_p_q & sda;
  assign ack_slot = rise & (bit_q == 4'h8);
  assign addr_exp = {`QDW_ADDR_TOP, addr_select_hi_i, addr_select_lo_i, 1'h0};
  // Follow starts, stops and bit slots on the wire
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      scl_p_q <= 1'h1;
      sda_p_q <= 1'h1;
      bit_q <= 4'h0;
      byte_q <= 3'h0;
      sh_q <= 8'h00;
      rs_q <= 1'h0;
      frm_q <= 1'h0;
      aack_q <= 1'h0;
    end else begin
      scl_p_q <= scl;
      sda_p_q <= sda;
      if (start_ev) begin
        // New or repeated start restarts the byte count
        bit_q <= 4'h0;
        byte_q <= 3'h0;
        rs_q <= frm_q;
        frm_q <= 1'h1;
        aack_q <= 1'h0;
      end else if (stop_ev) begin
        frm_q <= 1'h0;
      end else if (ack_slot) begin
        // Ninth pulse closes the byte slot
        bit_q <= 4'h0;
        byte_q <= (byte_q == 3'h7) ? byte_q : byte_q + 3'h1;
        if (byte_q == 3'h0) begin
          aack_q <= ~sda;
        end
      end else if (rise) begin
        bit_q <= bit_q + 4'h1;
        sh_q <= {sh_q[6:0], sda};
      end
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  chk_drive_low_only: assert property (
    (scl_m_oe |-> !scl_m_o) and (sda_s_oe |-> !sda_s_o))
    else $error("link driver drives a high level");
  chk_ack_edge_low: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("receiver moved data line while clock high");
  chk_low_bounded: assert property ($fell(scl) |-> ##[1:LOW_MAX] scl)
    else $error("clock line held low too long");
  chk_high_min: assert property ($rose(scl) |-> scl[*8])
    else $error("clock high phase too short");
  chk_no_fight: assert property ((sda_s_oe && scl) |-> !sda_m_oe)
    else $error("both ends drive data line in acknowledge");
  chk_mcode_nack: assert property (
    (ack_slot && !rs_q && byte_q == 3'h0) |-> sda)
    else $error("master code was acknowledged");
  chk_addr_ack: assert property (
    (ack_slot && rs_q && byte_q == 3'h0 && sh_q == addr_exp) |-> !sda)
    else $error("matching address not acknowledged");
  chk_addr_nack: assert property (
    (ack_slot && rs_q && byte_q == 3'h0 && sh_q != addr_exp) |-> sda)
    else $error("foreign address acknowledged");
  chk_ctrl_ack: assert property (
    (ack_slot && rs_q && aack_q && byte_q == 3'h1 && !sh_q[3]) |-> !sda)
    else $error("control byte not acknowledged");
  chk_data_ack: assert property (
    (ack_slot && aack_q && (byte_q == 3'h2 || byte_q == 3'h3)) |-> !sda)
    else $error("data byte not acknowledged");
  chk_pair_then_stop: assert property (
    (ack_slot && aack_q && byte_q == 3'h3) |-> ##[1:LOW_MAX] stop_ev)
    else $error("controller did not stop after the pair");
endmodule : qdw_assertions
`default_nettype wire

/* File: bench/quad_dac_hs_write_receiver_tb.sv */
// Testbench joining controller and receiver over the two-wire link
`timescale 1ns/1ps
`default_nettype none
`include "qdw_map.svh"
module quad_dac_hs_write_receiver_tb;
  import qdw_pkg::*;
  localparam int Q = 48; // Quarter bit in system clocks
  localparam logic [7:0] ADDR = {`QDW_ADDR_TOP, 3'h4}; // Pins hi=1 lo=0
  logic clk_sys = 1'h0;
  logic clk_lnk = 1'h0;
  logic rst_sys = 1'h1;
  logic rst_lnk = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sel_hi = 1'h1; // Address strap pins
  logic sel_lo = 1'h0;
  qdw_bank_t tmp_a, out_a, tmp_b, out_b; // Channel registers of both receivers
  logic pdf_a;
  logic upd_b;
  int miscompares = 0;
  int checked = 0;
  int upd_n_b = 0; // Output loads seen on the second receiver
  logic [8:0] mon_q[$]; // Bytes with their acknowledge bit
  logic scl_p = 1'h1;
  logic sda_p = 1'h1;
  logic [7:0] sh = 8'h00;
  int nb = 0;
  qdw_if lnk ();
  qdw_if lnk2 (); // Second link driven by the bench itself
  // Clocks, the link one unrelated in phase
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    #7;
    forever #24 clk_lnk = ~clk_lnk;
  end
  initial begin
    repeat (12) @(posedge clk_lnk);
    rst_lnk <= 1'h0;
  end
  qdw_host #(.QTR(Q)) qdw_host_inst (.clk_sys_i(clk_sys), .rst_i(rst_sys),
    .ce_i(1'h1), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .lnk(lnk.host));
  qdw_dev qdw_dev_inst (.clk_lnk_i(clk_lnk), .rst_i(rst_lnk), .ce_i(1'h1),
    .addr_select_hi_i(sel_hi), .addr_select_lo_i(sel_lo), .lnk(lnk.dev),
    .channel_temp_reg_o(tmp_a), .channel_output_reg_o(out_a),
    .update_o(), .powerdown_flag_o(pdf_a));
  qdw_dev qdw_dev_inst2 (.clk_lnk_i(clk_lnk), .rst_i(rst_lnk), .ce_i(1'h1),
    .addr_select_hi_i(sel_hi), .addr_select_lo_i(sel_lo), .lnk(lnk2.dev),
    .channel_temp_reg_o(tmp_b), .channel_output_reg_o(out_b),
    .update_o(upd_b), .powerdown_flag_o());
  qdw_assertions #(.QTR(Q)) qdw_assertions_inst (.clk_sys_i(clk_sys),
    .rst_i(rst_sys), .addr_select_hi_i(sel_hi), .addr_select_lo_i(sel_lo),
    .scl_m_o(lnk.scl_m_o), .scl_m_oe(lnk.scl_m_oe), .sda_m_oe(lnk.sda_m_oe),
    .sda_s_o(lnk.sda_s_o), .sda_s_oe(lnk.sda_s_oe), .scl(lnk.scl),
    .sda(lnk.sda));
  // Collect bytes seen on the first link, restarting on each start
  always @(posedge clk_sys) begin
    if (lnk.scl && scl_p && sda_p && !lnk.sda) begin
      nb = 0;
    end else if (lnk.scl && !scl_p) begin
      if (nb == 8) begin
        mon_q.push_back({sh, lnk.sda});
        nb = 0;
      end else begin
        sh = {sh[6:0], lnk.sda};
        nb++;
      end
    end
    scl_p = lnk.scl;
    sda_p = lnk.sda;
  end
  // Count output loads of the second receiver
  always @(posedge clk_lnk) begin
    if (upd_b === 1'h1) upd_n_b++;
  end
  task automatic report_and_stop();
    if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [31:0] got,
                       input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // One APB transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk_sys);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'h1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 50) begin
      miscompares++;
      report_and_stop();
    end
  endtask : apb
  // Program and start one write, then poll until done or refused
  task automatic host_write(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    int n;
    apb(1'h1, `QDW_REG_CTRL, c, r, e);
    apb(1'h1, `QDW_REG_DATA, d, r, e);
    apb(1'h1, `QDW_REG_STAT, 32'h7, r, e);
    mon_q.delete();
    apb(1'h1, `QDW_REG_CMD, 32'h1, r, e);
    n = 0;
    do begin
      apb(1'h0, `QDW_REG_STAT, 32'h0, r, e);
      n++;
    end while (r[2] !== 1'h1 && n < 9000);
    if (n >= 9000) begin
      miscompares++;
      report_and_stop();
    end
  endtask : host_write
  // Compare collected bytes with a right-aligned list, first byte highest
  task automatic cmp_mon(input int n, input logic [4:0][8:0] e);
    check("byte count", 32'(mon_q.size()), 32'(n));
    for (int i = 0; i < n; i++) check("byte", 32'(mon_q[i]), 32'(e[n-1-i]));
  endtask : cmp_mon
  task automatic sc_data();
    host_write({22'h0, 2'h2, 8'h14}, 32'h0A5C);
    cmp_mon(5, {{`QDW_MCODE_BYTE, 1'h1}, {ADDR, 1'h0}, {8'h14, 1'h0},
      {8'hA5, 1'h0}, {8'hC0, 1'h0}});
    check("temp ch2", 32'(tmp_a[2]), 32'h0A5C);
    check("out ch2", 32'(out_a[2]), 32'h0A5C);
    check("pd flag", 32'(pdf_a), 32'h0);
  endtask : sc_data
  task automatic sc_pdown();
    host_write({22'h0, 2'h2, 8'h23}, 32'h2000);
    cmp_mon(5, {{`QDW_MCODE_BYTE, 1'h1}, {ADDR, 1'h0}, {8'h23, 1'h0},
      {8'h80, 1'h0}, {8'h00, 1'h0}});
    check("temp ch1", 32'(tmp_a[1]), 32'h2000);
    check("out ch1", 32'(out_a[1]), 32'h2000);
    check("out ch2", 32'(out_a[2]), 32'h0A5C);
    check("pd flag", 32'(pdf_a), 32'h1);
  endtask : sc_pdown
  // Foreign address, then status clear and an unmapped read
  task automatic sc_refuse();
    logic [31:0] r;
    logic e;
    host_write({22'h0, 2'h1, 8'h14}, 32'h0FFF);
    cmp_mon(2, {27'h0, {`QDW_MCODE_BYTE, 1'h1}, {8'h9A, 1'h1}});
    apb(1'h0, `QDW_REG_STAT, 32'h0, r, e);
    check("addr nack", 32'(r[1]), 32'h1);
    check("temp kept", 32'(tmp_a[2]), 32'h0A5C);
    apb(1'h1, `QDW_REG_STAT, 32'h7, r, e);
    apb(1'h0, `QDW_REG_STAT, 32'h0, r, e);
    check("stat clear", r, 32'h0);
    apb(1'h0, 8'h10, 32'h0, r, e);
    check("unmapped err", 32'(e), 32'h1);
    check("unmapped data", r, 32'h0);
  endtask : sc_refuse
  // Bench-driven quarter of a bit slot on the second link
  task automatic qt(input logic c, input logic d);
    @(posedge clk_sys);
    lnk2.scl_m_oe <= ~c;
    lnk2.sda_m_oe <= ~d;
    repeat (Q - 1) @(posedge clk_sys);
  endtask : qt
  task automatic rstart();
    qt(1'h0, 1'h1);
    qt(1'h1, 1'h1);
    qt(1'h1, 1'h0);
    qt(1'h0, 1'h0);
  endtask : rstart
  // Send one byte and compare the acknowledge bit with the expected one
  task automatic xb(input logic [7:0] b, input logic exp);
    logic a;
    for (int i = 8; i >= 0; i--) begin
      qt(1'h0, (i > 0) ? b[i-1] : 1'h1);
      qt(1'h0, (i > 0) ? b[i-1] : 1'h1);
      qt(1'h1, (i > 0) ? b[i-1] : 1'h1);
      qt(1'h1, (i > 0) ? b[i-1] : 1'h1);
      a = lnk2.sda;
    end
    check("lnk2 ack", 32'(a), 32'(exp));
  endtask : xb
  task automatic sc_link2();
    rstart();
    xb(`QDW_MCODE_BYTE, 1'h1);
    rstart();
    xb(ADDR, 1'h0);
    xb(8'h17, 1'h0);
    xb(8'h40, 1'h0);
    xb(8'h00, 1'h0);
    xb(8'h55, 1'h1);
    rstart();
    xb(ADDR | 8'h01, 1'h1);
    rstart();
    xb(ADDR, 1'h0);
    xb(8'h10, 1'h0);
    xb(8'h12, 1'h0);
    xb(8'h30, 1'h0);
    xb(8'hFE, 1'h0);
    xb(8'hD5, 1'h0);
    qt(1'h0, 1'h0);
    qt(1'h1, 1'h0);
    qt(1'h1, 1'h1);
    check("b temp ch3", 32'(tmp_b[3]), 32'h1000);
    check("b out ch3", 32'(out_b[3]), 32'h1000);
    check("b out ch0", 32'(out_b[0]), 32'h0FED);
    check("b loads", 32'(upd_n_b), 32'h3);
  endtask : sc_link2
  // Main sequence
  initial begin
    lnk2.scl_m_o = 1'h0;
    lnk2.sda_m_o = 1'h0;
    lnk2.scl_m_oe = 1'h0;
    lnk2.sda_m_oe = 1'h0;
    repeat (12) @(posedge clk_sys);
    rst_sys <= 1'h0;
    repeat (16) @(posedge clk_lnk);
    sc_data();
    sc_pdown();
    sc_refuse();
    sc_link2();
    report_and_stop();
  end
endmodule : quad_dac_hs_write_receiver_tb
`default_nettype wire
